// ### verilog/fbsr_map.svh
// constants of the flow-through burst sram core
`ifndef FBSR_MAP_SVH
`define FBSR_MAP_SVH
`define FBSR_WORDS_X36 32'h0020_0000
`define FBSR_WORDS_X18 32'h0040_0000
`define FBSR_WORDS_X72 32'h0010_0000
`define FBSR_ADDR_W_X36 21
`define FBSR_DATA_W_X36 36
`define FBSR_LANE_W 9
`define FBSR_BEAT_W 2
`define FBSR_BEAT_ZERO 2'h0
`define FBSR_BEAT_STEP 2'h1
`endif

// ### verilog/fbsr_pkg.sv
// types of the flow-through burst sram core
package fbsr_pkg;
  typedef enum logic [1:0] {
    op_idle,
    op_read,
    op_write
  } fbsr_op_t;
endpackage

// ### verilog/fbsr_top.sv
// flow-through burst sram core with zero read/write turnaround
//
// Overview of operation
// R1 - every synchronous input sampled on rising clock
// R2 - reads and writes mix back to back
// R3 - suspend high freezes every internal register; the reset release flops keep clocking
// R4 - deselected load starts nothing, stops burst
// R5 - pending read or write still completes
// R6 - bus floats one cycle after deselect/write
// R7 - two-bit counter gives four beats per address
// R8 - unclocked order pin picks linear or interleaved
// R9 - load takes address, advance steps counter
// R10 - output enable floats bus asynchronously
// R11 - unused sleep input tied low outside
// R12 - three chip selects, low/high/low active
// R13 - one write select per nine-bit lane
// R14 - array depth follows chosen organisation
// R15 - counter steps two low address bits
// R16 - low control writes, high reads, data next
// R17 - read data leaves without extra output stage
`timescale 1ns/10ps
`include "fbsr_map.svh"

module fbsr_top #(
  parameter int DATA_W = `FBSR_DATA_W_X36,
  parameter int ADDR_W = `FBSR_ADDR_W_X36,
  parameter int WORDS = `FBSR_WORDS_X36,
  parameter int LANES = DATA_W / `FBSR_LANE_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // address and control
  input wire logic [ADDR_W-1:0] address,
  input wire logic advance_or_load,
  input wire logic clock_suspend_n,
  input wire logic write_enable_n,
  input wire logic [LANES-1:0] byte_lane_write_n,
  // chip selects
  input wire logic chip_select_first_n,
  input wire logic chip_select_second,
  input wire logic chip_select_third_n,
  // asynchronous controls
  input wire logic output_enable_n,
  input wire logic burst_order_interleaved,
  // common data bus
  input wire logic [DATA_W-1:0] data_io_in,
  output logic [DATA_W-1:0] data_io_out,
  output logic data_io_oe
);

  // array sized by organisation
  logic [DATA_W-1:0] mem [0:WORDS-1]; // [R14]

  // reset release
  logic rst_meta;
  logic rst_sync_n;
  logic next_rst_meta;
  logic next_rst_sync_n;

  // access state
  fbsr_pkg::fbsr_op_t op;
  fbsr_pkg::fbsr_op_t next_op;
  logic [ADDR_W-1:0] base_addr;
  logic [ADDR_W-1:0] next_base_addr;
  logic [`FBSR_BEAT_W-1:0] beat;
  logic [`FBSR_BEAT_W-1:0] next_beat;

  // pending write beat
  logic wr_pend;
  logic next_wr_pend;
  logic [ADDR_W-1:0] wr_addr;
  logic [ADDR_W-1:0] next_wr_addr;
  logic [LANES-1:0] wr_lanes_n;
  logic [LANES-1:0] next_wr_lanes_n;

  // read output stage
  logic rd_drive;
  logic next_rd_drive;
  logic [DATA_W-1:0] dout;
  logic [DATA_W-1:0] next_dout;

  // decode helpers
  logic selected;
  logic start;
  logic advance;
  logic [ADDR_W-1:0] access_addr;
  logic [DATA_W-1:0] wr_word;
  logic [DATA_W-1:0] rd_word;
  fbsr_pkg::fbsr_op_t access_op;
  logic running;
  logic mem_we;

  // low address bits of a burst beat
  function automatic logic [ADDR_W-1:0] burst_addr(
    input logic [ADDR_W-1:0] base,
    input logic [`FBSR_BEAT_W-1:0] count,
    input logic interleaved
  );
    logic [`FBSR_BEAT_W-1:0] low;
    logic [ADDR_W-1:0] result;
    if (interleaved) begin
      low = base[`FBSR_BEAT_W-1:0] ^ count; // [R15] [R8]
    end else begin
      low = base[`FBSR_BEAT_W-1:0] + count; // [R15] [R8]
    end
    result = base;
    result[`FBSR_BEAT_W-1:0] = low;
    return result;
  endfunction

  // apply write data on lanes whose select is low
  function automatic logic [DATA_W-1:0] lane_merge(
    input logic [DATA_W-1:0] old_word,
    input logic [DATA_W-1:0] new_word,
    input logic [LANES-1:0] lanes_n
  );
    logic [DATA_W-1:0] result;
    result = old_word;
    for (int i = 0; i < LANES; i++) begin
      if (!lanes_n[i]) begin
        result[i*`FBSR_LANE_W +: `FBSR_LANE_W] =
          new_word[i*`FBSR_LANE_W +: `FBSR_LANE_W]; // [R13]
      end
    end
    return result;
  endfunction

  // kind of access a selected load starts
  function automatic fbsr_pkg::fbsr_op_t load_kind(
    input logic write_n
  );
    fbsr_pkg::fbsr_op_t kind;
    kind = fbsr_pkg::op_write;
    if (write_n) begin
      kind = fbsr_pkg::op_read; // [R16]
    end
    return kind;
  endfunction

  // reset release: the flops fill with ones behind rst_n
  always_comb begin
    next_rst_meta = 1'b1;
    next_rst_sync_n = rst_meta;
  end

  // two-flop release of the asynchronous reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= next_rst_meta;
      rst_sync_n <= next_rst_sync_n;
    end
  end

  // a load needs all three selects active
  assign selected = !chip_select_first_n && chip_select_second
                    && !chip_select_third_n; // [R12]
  assign start = !advance_or_load && selected; // [R9]
  // an advance only counts inside a burst
  assign advance = advance_or_load && (op != fbsr_pkg::op_idle); // [R9]

  // write data sampled one cycle after its address
  assign wr_word = lane_merge(mem[wr_addr], data_io_in, wr_lanes_n); // [R16]

  // address and kind of the beat taken at this edge
  always_comb begin
    access_addr = base_addr;
    access_op = fbsr_pkg::op_idle;
    if (start) begin
      access_addr = address;
      access_op = load_kind(write_enable_n); // [R16]
    end else if (advance) begin
      access_addr = burst_addr(base_addr, beat + `FBSR_BEAT_STEP,
                               burst_order_interleaved); // [R7]
      access_op = op;
    end
  end

  // a read just behind a write to the same word sees the new data
  always_comb begin
    rd_word = mem[access_addr];
    if (wr_pend && (wr_addr == access_addr)) begin
      rd_word = wr_word; // [R2]
    end
  end

  // a suspended edge leaves every register but the reset release flops, and the array, alone
  assign running = !clock_suspend_n; // [R3]

  // next state of the burst sequencer
  always_comb begin
    next_op = op;
    next_base_addr = base_addr;
    next_beat = beat;
    if (running) begin
      if (!advance_or_load) begin
        if (selected) begin
          next_op = access_op; // [R9]
          next_base_addr = address; // [R1]
          next_beat = `FBSR_BEAT_ZERO;
        end else begin
          // a deselected load ends any burst in flight
          next_op = fbsr_pkg::op_idle; // [R4]
        end
      end else begin
        case (op)
          fbsr_pkg::op_read, fbsr_pkg::op_write: begin
            next_beat = beat + `FBSR_BEAT_STEP; // [R7]
          end
          default: begin
            // an advance with no burst in flight is ignored
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      op <= fbsr_pkg::op_idle;
      base_addr <= '0;
      beat <= `FBSR_BEAT_ZERO;
    end else begin
      op <= next_op;
      base_addr <= next_base_addr;
      beat <= next_beat;
    end
  end

  // next state of the pending write beat; its data comes one run edge later
  always_comb begin
    next_wr_pend = wr_pend;
    next_wr_addr = wr_addr;
    next_wr_lanes_n = wr_lanes_n;
    if (running) begin
      next_wr_pend = 1'b0;
      if (access_op == fbsr_pkg::op_write) begin
        next_wr_pend = 1'b1;
        next_wr_addr = access_addr;
        next_wr_lanes_n = byte_lane_write_n; // [R1] [R13]
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
      wr_lanes_n <= '1;
    end else begin
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      wr_lanes_n <= next_wr_lanes_n;
    end
  end

  // next state of the read stage; a write or idle edge frees the bus
  always_comb begin
    next_rd_drive = rd_drive;
    next_dout = dout;
    if (running) begin
      next_rd_drive = 1'b0; // [R6]
      if (access_op == fbsr_pkg::op_read) begin
        next_rd_drive = 1'b1;
        next_dout = rd_word; // [R17]
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rd_drive <= 1'b0;
      dout <= '0;
    end else begin
      rd_drive <= next_rd_drive;
      dout <= next_dout;
    end
  end

  // a pending write lands at the next run edge, selected or not
  always_comb begin
    mem_we = rst_sync_n && running && wr_pend; // [R5]
  end

  // the array has no reset; only the write port is clocked
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[wr_addr] <= wr_word; // [R5]
    end
  end

  // read data straight from the output flop, no further stage
  assign data_io_out = dout;
  // output enable gates the pins at once, with no clock
  assign data_io_oe = rd_drive && !output_enable_n; // [R10] [R6]

endmodule // fbsr_top

// ### tb/fbsr_ctl_bus.sv
// bus level seen by the core: core, controller or a floating pattern
`timescale 1ns/10ps
module fbsr_ctl_bus (
  // clock
  input wire logic clk,
  // drivers
  input wire logic [35:0] dev_out,
  input wire logic dev_oe,
  input wire logic [35:0] ctl_data,
  input wire logic ctl_oe,
  // resolved level
  output logic [35:0] bus
);
  // sleep_request is held low on the board; the core has no such pin
  logic [35:0] last;
  always_ff @(posedge clk) last <= bus;
  // a released bus flips each cycle so no stale word passes as data
  always_comb bus = dev_oe ? dev_out : ctl_oe ? ctl_data : ~last;
endmodule // fbsr_ctl_bus

// ### tb/fbsr_top_chk.sv
// port assertions of the flow-through burst sram core
`timescale 1ns/10ps
module fbsr_top_chk #(parameter int DATA_W = 36) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic advance_or_load,
  input wire logic clock_suspend_n,
  input wire logic write_enable_n,
  input wire logic chip_select_first_n,
  input wire logic chip_select_second,
  input wire logic chip_select_third_n,
  input wire logic output_enable_n,
  // data bus
  input wire logic [DATA_W-1:0] data_io_out,
  input wire logic data_io_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire sel = !chip_select_first_n && chip_select_second && !chip_select_third_n;
  wire ld = !clock_suspend_n && !advance_or_load;
  sequence rd_ld; ld && sel && write_enable_n; endsequence
  sequence step; !clock_suspend_n && advance_or_load; endsequence
  read_drive_a: assert property (rd_ld |=> data_io_oe || output_enable_n)
    else $error("read load left bus idle");
  desel_float_a: assert property (ld && !sel |=> !data_io_oe)
    else $error("bus driven after deselect");
  write_float_a: assert property (ld && sel && !write_enable_n |=> !data_io_oe)
    else $error("bus driven after write load");
  burst_keep_a: assert property (data_io_oe ##0 step |=> data_io_oe || output_enable_n)
    else $error("read burst stopped");
  idle_adv_a: assert property ((!data_io_oe && !output_enable_n) ##0 step |=> !data_io_oe)
    else $error("advance started a read");
  oe_gate_a: assert property (output_enable_n |-> !data_io_oe)
    else $error("bus driven while disabled");
  hold_data_a: assert property (clock_suspend_n |=> $stable(data_io_out))
    else $error("data moved while suspended");
  hold_oe_a: assert property ((clock_suspend_n && !output_enable_n) ##1 !output_enable_n
    |-> $stable(data_io_oe)) else $error("enable moved while suspended");
endmodule // fbsr_top_chk
bind fbsr_top fbsr_top_chk #(.DATA_W(DATA_W)) i_fbsr_top_chk (.clk, .rst_n, .advance_or_load,
  .clock_suspend_n, .write_enable_n, .chip_select_first_n, .chip_select_second,
  .chip_select_third_n, .output_enable_n, .data_io_out, .data_io_oe);

// ### tb/fbsr_top_tb.sv
// bench of the flow-through burst sram core
`timescale 1ns/10ps
module fbsr_top_tb;
  logic clk = 0, rst_n = 0, advance_or_load = 1, clock_suspend_n = 0, write_enable_n = 1;
  logic chip_select_first_n = 1, output_enable_n = 0, burst_order_interleaved = 0, ctl_oe = 0;
  logic data_io_oe;
  logic chip_select_second = 1, chip_select_third_n = 0;
  logic [3:0] byte_lane_write_n = 4'hF, wl = 4'h0;
  logic [35:0] data_io_in, data_io_out, ctl_data = 36'h0, mem_exp [4];
  logic [20:0] address = 21'h01_2345;
  int miscompares = 0, n_tests = 0;
  fbsr_top i_fbsr_top (.clk, .rst_n, .address, .advance_or_load, .clock_suspend_n,
    .write_enable_n, .byte_lane_write_n, .chip_select_first_n, .chip_select_second,
    .chip_select_third_n, .output_enable_n, .burst_order_interleaved, .data_io_in,
    .data_io_out, .data_io_oe);
  fbsr_ctl_bus i_fbsr_ctl_bus (.clk, .dev_out(data_io_out), .dev_oe(data_io_oe), .ctl_data,
    .ctl_oe, .bus(data_io_in));
  initial forever #2.5 clk = ~clk;
  task chk(input string nm, input logic [35:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  function logic [1:0] lo(input int i);
    return burst_order_interleaved ? 2'(address[1:0] ^ i) : 2'(address[1:0] + i);
  endfunction
  task load(input logic wr_n, cs_n);
    @(posedge clk);
    advance_or_load <= 0;
    write_enable_n <= wr_n;
    chip_select_first_n <= cs_n;
    byte_lane_write_n <= wl;
  endtask
  task adv;
    @(posedge clk);
    advance_or_load <= 1;
  endtask
  // data of each beat follows its address by one cycle; ends with a read load
  task wr_burst(input logic [35:0] pat);
    logic [35:0] d;
    for (int i = 0; i < 4; i++) begin
      if (i < 3) adv();
      else load(1, 0);
      d = pat + 36'(i);
      ctl_data <= d;
      ctl_oe <= 1;
      for (int l = 0; l < 4; l++) if (!wl[l]) mem_exp[lo(i)][9*l+:9] = d[9*l+:9];
    end
  endtask
  // ends with a write load or a deselect
  task rd_beats(input logic to_wr);
    for (int i = 0; i < 4; i++) begin
      if (i < 3) adv();
      else load(!to_wr, !to_wr);
      ctl_oe <= 0;
      @(negedge clk);
      chk("read", data_io_out, mem_exp[lo(i)]);
    end
    if (!to_wr) begin
      @(negedge clk);
      chk("float", 36'(data_io_oe), 36'h0);
    end
  endtask
  task t_mixed;
    load(0, 0);
    wr_burst(36'h5_A5A5_A5A0);
    wl = 4'hE;
    rd_beats(1);
    wr_burst(36'h3_C3C3_C3C0);
    rd_beats(0);
  endtask
  task t_order;
    load(1, 0);
    burst_order_interleaved <= 1;
    rd_beats(0);
  endtask
  // the second or third select alone ends a read burst and floats the bus
  task t_desel(input int which);
    load(1, 0);
    @(posedge clk);
    if (which == 2) chip_select_second <= 0;
    else chip_select_third_n <= 1;
    @(negedge clk);
    chk("sel read", data_io_out, mem_exp[lo(0)]);
    @(negedge clk);
    chk("sel float", 36'(data_io_oe), 36'h0);
    @(posedge clk);
    chip_select_second <= 1;
    chip_select_third_n <= 0;
  endtask
  task t_suspend;
    load(1, 0);
    @(posedge clk);
    clock_suspend_n <= 1;
    chip_select_first_n <= 1;
    repeat (3) begin
      @(negedge clk);
      chk("held", data_io_out, mem_exp[lo(0)]);
    end
    adv();
    clock_suspend_n <= 0;
    chip_select_first_n <= 0;
    repeat (2) @(negedge clk);
    chk("next", data_io_out, mem_exp[lo(1)]);
    @(posedge clk);
    output_enable_n <= 1;
    @(negedge clk);
    chk("oe", 36'(data_io_oe), 36'h0);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    t_mixed;
    t_order;
    t_desel(2);
    t_desel(3);
    t_suspend;
    summarize;
  end
  initial begin
    repeat (400) @(posedge clk);
    miscompares++;
    $display("MISMATCH watchdog expected done seen timeout");
    summarize;
  end
endmodule // fbsr_top_tb
